// [logic/jtb_defs.vh]
// Constants of the test access port block: states, instruction codes, register widths, FIFO depth.
`ifndef JTB_DEFS_VH
`define JTB_DEFS_VH

// State codes of the sixteen-state controller
`define JTB_ST_RESET      4'h0
`define JTB_ST_IDLE       4'h1
`define JTB_ST_SEL_DR     4'h2
`define JTB_ST_CAP_DR     4'h3
`define JTB_ST_SHIFT_DR   4'h4
`define JTB_ST_EXIT1_DR   4'h5
`define JTB_ST_PAUSE_DR   4'h6
`define JTB_ST_EXIT2_DR   4'h7
`define JTB_ST_UPD_DR     4'h8
`define JTB_ST_SEL_IR     4'h9
`define JTB_ST_CAP_IR     4'ha
`define JTB_ST_SHIFT_IR   4'hb
`define JTB_ST_EXIT1_IR   4'hc
`define JTB_ST_PAUSE_IR   4'hd
`define JTB_ST_EXIT2_IR   4'he
`define JTB_ST_UPD_IR     4'hf

// Instruction register
`define JTB_IR_W          8
`define JTB_IR_CAPTURE    8'h81
`define JTB_IR_BYPASS     8'hff
`define JTB_IR_RESET_VAL  8'hff

// Generic data register width and its reset value
`define JTB_DR_W          8
`define JTB_DR_RESET_VAL  8'h00

// Bypass captures zero
`define JTB_BYP_CAPTURE   1'b0

// FIFO depth in front of the update port
`define JTB_FIFO_DEPTH    8
`define JTB_FIFO_AW       3

`endif

// [logic/jtb_fifo.v]
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module jtb_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk,
	input  wire             arst_n,
	input  wire             ce,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output reg  [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_q;
	reg [AW-1:0]    rd_q;
	reg [AW:0]      cnt_q;
	wire            push;
	wire            pop;
	wire [AW-1:0]   rd_nx;

	// Full and empty come straight from the occupancy count
	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;
	assign rd_nx     = pop ? rd_q + 1'b1 : rd_q;

	// Storage array has no reset; pointers, count and head word do
	always @(posedge clk) begin
		if (push)
			mem[wr_q] <= in_data;
	end

	// Pointers and count
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	// Registered head word follows the next read slot; a write into that slot
	// is forwarded, so valid and data never disagree for a cycle
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			out_data <= {WIDTH{1'b0}};
		else if (ce) begin
			if (push && (wr_q == rd_nx))
				out_data <= in_data;
			else
				out_data <= mem[rd_nx];
		end
	end
endmodule // jtb_fifo
`default_nettype wire

// [logic/jtb_tap.v]
// Test access port: controller, instruction, bypass and data registers.
// What this block does
// - Leaving capture-IR loads the instruction shifter with 10000001.
// - Serial output is enabled on the falling edge after entering a shift state.
// - In shift-IR one bit enters per rising edge while old contents shift out.
// - Last instruction bit shifts on the edge moving shift-IR to exit1-IR.
// - All-ones instruction decodes as bypass once updated.
// - Update-IR moves the shifted instruction into the active latch on falling edge.
// - Reaching exit1 tristates the serial output on the falling edge.
// - Bypass register captures zero on the edge leaving capture-DR.
// - Bypass delays serial input by one stage; 101 in gives 010 out.
// - Update-DR queues shifted data on falling edge, unless bypass is selected or the queue is full.
// - Inputs sampled on rising test clock; serial output and instruction latch change only on falling edges.
`timescale 1ns/10ps
`default_nettype none
`include "jtb_defs.vh"
module jtb_tap #(
	parameter IR_W  = `JTB_IR_W,
	parameter DR_W  = `JTB_DR_W,
	parameter DEPTH = `JTB_FIFO_DEPTH,
	parameter AW    = `JTB_FIFO_AW
) (
	input  wire            core_clk,
	input  wire            arst_n,
	input  wire            clk_en,
	input  wire            tck,
	input  wire            tms,
	input  wire            tdi,
	output reg             tdo_o,
	output reg             tdo_oe,
	output reg  [IR_W-1:0] instr_q,
	output wire            bypass_sel,
	output wire [DR_W-1:0] upd_data,
	output wire            upd_valid,
	input  wire            upd_ready,
	output wire            upd_stall,
	output wire [3:0]      tap_state
);
	// Controller state codes
	localparam [3:0] ST_RESET    = `JTB_ST_RESET;
	localparam [3:0] ST_IDLE     = `JTB_ST_IDLE;
	localparam [3:0] ST_SEL_DR   = `JTB_ST_SEL_DR;
	localparam [3:0] ST_CAP_DR   = `JTB_ST_CAP_DR;
	localparam [3:0] ST_SHIFT_DR = `JTB_ST_SHIFT_DR;
	localparam [3:0] ST_EXIT1_DR = `JTB_ST_EXIT1_DR;
	localparam [3:0] ST_PAUSE_DR = `JTB_ST_PAUSE_DR;
	localparam [3:0] ST_EXIT2_DR = `JTB_ST_EXIT2_DR;
	localparam [3:0] ST_UPD_DR   = `JTB_ST_UPD_DR;
	localparam [3:0] ST_SEL_IR   = `JTB_ST_SEL_IR;
	localparam [3:0] ST_CAP_IR   = `JTB_ST_CAP_IR;
	localparam [3:0] ST_SHIFT_IR = `JTB_ST_SHIFT_IR;
	localparam [3:0] ST_EXIT1_IR = `JTB_ST_EXIT1_IR;
	localparam [3:0] ST_PAUSE_IR = `JTB_ST_PAUSE_IR;
	localparam [3:0] ST_EXIT2_IR = `JTB_ST_EXIT2_IR;
	localparam [3:0] ST_UPD_IR   = `JTB_ST_UPD_IR;

	// Two-flop synchronisers; only stage two is read by logic
	reg  [2:0] s1_q;
	reg  [2:0] s2_q;
	reg        tck_prev_q;
	wire       tck_s;
	wire       tms_s;
	wire       tdi_s;
	wire       rise;
	wire       fall;

	reg  [3:0]      st_q;
	reg  [3:0]      st_d;
	reg  [IR_W-1:0] ir_sh_q;
	reg             byp_q;
	reg  [DR_W-1:0] dr_sh_q;
	reg             out_bit;
	wire            shifting;
	wire            push;
	wire            fifo_rdy;

	assign tck_s      = s2_q[0];
	assign tms_s      = s2_q[1];
	assign tdi_s      = s2_q[2];
	assign rise       = tck_s && !tck_prev_q;
	assign fall       = !tck_s && tck_prev_q;
	assign tap_state  = st_q;
	assign bypass_sel = (instr_q == `JTB_IR_BYPASS);
	assign upd_stall  = !fifo_rdy;
	assign shifting   = (st_q == ST_SHIFT_IR) || (st_q == ST_SHIFT_DR);

	// Synchronise the link pins into the core clock domain
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q       <= 3'h0;
			s2_q       <= 3'h0;
			tck_prev_q <= 1'b0;
		end else if (clk_en) begin
			s1_q       <= {tdi, tms, tck};
			s2_q       <= s1_q;
			tck_prev_q <= tck_s;
		end
	end

	// Next-state graph of the controller
	always @* begin
		case (st_q)
		ST_RESET:    st_d = tms_s ? ST_RESET : ST_IDLE;
		ST_IDLE:     st_d = tms_s ? ST_SEL_DR : ST_IDLE;
		ST_SEL_DR:   st_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
		ST_CAP_DR:   st_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
		ST_SHIFT_DR: st_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
		ST_EXIT1_DR: st_d = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
		ST_PAUSE_DR: st_d = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
		ST_EXIT2_DR: st_d = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
		ST_UPD_DR:   st_d = tms_s ? ST_SEL_DR : ST_IDLE;
		ST_SEL_IR:   st_d = tms_s ? ST_RESET : ST_CAP_IR;
		ST_CAP_IR:   st_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
		ST_SHIFT_IR: st_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
		ST_EXIT1_IR: st_d = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
		ST_PAUSE_IR: st_d = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
		ST_EXIT2_IR: st_d = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
		ST_UPD_IR:   st_d = tms_s ? ST_SEL_DR : ST_IDLE;
		default:     st_d = ST_RESET;
		endcase
	end

	// Controller state moves only on a detected test-clock rise
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			st_q <= ST_RESET;
		else if (clk_en && rise)
			st_q <= st_d;
	end

	// Instruction shifter; capture and shift act on the state being left,
	// so the last bit goes in on the very edge that moves to exit1
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			ir_sh_q <= `JTB_IR_CAPTURE;
		else if (clk_en && rise) begin
			if (st_q == ST_CAP_IR)
				ir_sh_q <= `JTB_IR_CAPTURE;
			else if (st_q == ST_SHIFT_IR)
				ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
		end
	end

	// Bypass stage: a known zero leads every bypass scan out
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			byp_q <= 1'b0;
		else if (clk_en && rise && bypass_sel) begin
			if (st_q == ST_CAP_DR)
				byp_q <= `JTB_BYP_CAPTURE;
			else if (st_q == ST_SHIFT_DR)
				byp_q <= tdi_s;
		end
	end

	// Generic data shifter, idle while bypass owns the scan path
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			dr_sh_q <= `JTB_DR_RESET_VAL;
		else if (clk_en && rise && !bypass_sel && (st_q == ST_SHIFT_DR))
			dr_sh_q <= {tdi_s, dr_sh_q[DR_W-1:1]};
	end

	// Serial bit chosen for the output stage
	always @* begin
		if (st_q == ST_SHIFT_IR)
			out_bit = ir_sh_q[0];
		else if (bypass_sel)
			out_bit = byp_q;
		else
			out_bit = dr_sh_q[0];
	end

	// Output pin and enable change only on a detected fall; the data bit
	// holds while the pin is released, so it never toggles undriven
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tdo_o  <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (clk_en && fall) begin
			tdo_oe <= shifting;
			if (shifting)
				tdo_o <= out_bit;
		end
	end

	// Active instruction latch: loaded from the shifter in update-IR,
	// forced back to bypass while the controller sits in reset
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			instr_q <= `JTB_IR_RESET_VAL;
		else if (clk_en && fall) begin
			if (st_q == ST_UPD_IR)
				instr_q <= ir_sh_q;
			else if (st_q == ST_RESET)
				instr_q <= `JTB_IR_RESET_VAL;
		end
	end

	// Update-DR pushes the shifted word into the parallel-latch queue
	// Stalls of the queue do not hold the link: a full queue drops the word
	assign push = clk_en && fall && (st_q == ST_UPD_DR) && !bypass_sel;

	jtb_fifo #(
		.WIDTH (DR_W),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_fifo (
		.clk       (core_clk),
		.arst_n    (arst_n),
		.ce        (clk_en),
		.in_data   (dr_sh_q),
		.in_valid  (push),
		.in_ready  (fifo_rdy),
		.out_data  (upd_data),
		.out_valid (upd_valid),
		.out_ready (upd_ready)
	);
endmodule // jtb_tap
`default_nettype wire

// [verification/jtb_ctl_model.sv]
// Scan controller model driving the test clock, mode and data pins
`timescale 1ns/10ps
`default_nettype none
module jtb_ctl_model (
	input wire logic clk,
	input wire logic tdo_o,
	input wire logic tdo_oe,
	output var logic tck,
	output var logic tms,
	output var logic tdi
);
	// Clock stands low between frames; mode high holds reset
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One test clock; pins change only as the clock falls
	task automatic step(input logic m, input logic d, output logic q, output logic oe);
		tms = m;
		tdi = d;
		repeat (4) @(negedge clk);
		tck = 1'b1;
		repeat (4) @(negedge clk);
		q = tdo_oe ? tdo_o : !tdo_o; // A released line reads as the opposite of its last bit
		oe = tdo_oe;
		tck = 1'b0;
	endtask
endmodule // jtb_ctl_model
`default_nettype wire

// [verification/jtb_tap_asserts.sv]
// Checker of controller state, instruction latch and serial output
`timescale 1ns/10ps
`default_nettype none
`include "jtb_defs.vh"
module jtb_tap_asserts (
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire logic       tdo_o,
	input wire logic       tdo_oe,
	input wire logic [7:0] instr_q,
	input wire logic       bypass_sel,
	input wire logic [3:0] tap_state
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// Output driven from a shift state, released from exit1
	AST_OE_ON:
	assert property ($rose(tdo_oe) |-> tap_state inside {`JTB_ST_SHIFT_IR, `JTB_ST_SHIFT_DR})
		else $error("oe on");
	AST_OE_OFF:
	assert property ($fell(tdo_oe) |-> tap_state inside {`JTB_ST_EXIT1_IR, `JTB_ST_EXIT1_DR})
		else $error("oe off");
	// First bit out is the captured value
	AST_CAP_IR:
	assert property ($rose(tdo_oe) && tap_state == `JTB_ST_SHIFT_IR |-> tdo_o)
		else $error("ir capture");
	AST_BYP_ZERO:
	assert property ($rose(tdo_oe) && bypass_sel && tap_state == `JTB_ST_SHIFT_DR |-> !tdo_o)
		else $error("bypass capture");
	AST_DECODE:
	assert property ($changed(bypass_sel)
		|-> tap_state inside {`JTB_ST_UPD_IR, `JTB_ST_RESET} && bypass_sel == (instr_q == `JTB_IR_BYPASS))
		else $error("decode");
	AST_LATCH:
	assert property ($changed(instr_q) |-> tap_state inside {`JTB_ST_UPD_IR, `JTB_ST_RESET})
		else $error("latch");
	// Exits from shift-IR and select-IR
	AST_IR_EXIT:
	assert property ($past(tap_state) == `JTB_ST_SHIFT_IR
		|-> tap_state inside {`JTB_ST_SHIFT_IR, `JTB_ST_EXIT1_IR}) else $error("ir exit");
	AST_SEL_IR:
	assert property ($past(tap_state) == `JTB_ST_SEL_IR
		|-> tap_state inside {`JTB_ST_SEL_IR, `JTB_ST_CAP_IR, `JTB_ST_RESET}) else $error("sel");
	// Main walks
	CV_UPD: cover property (tap_state == `JTB_ST_UPD_IR);
	CV_BYP: cover property (bypass_sel && tdo_oe);
	CV_END: cover property (tap_state == `JTB_ST_SEL_IR ##1 tap_state == `JTB_ST_RESET);
endmodule // jtb_tap_asserts
bind jtb_tap jtb_tap_asserts u_jtb_tap_asserts (.core_clk, .arst_n, .tdo_o, .tdo_oe,
	.instr_q, .bypass_sel, .tap_state);
`default_nettype wire

// [verification/tb.sv]
// Testbench: instruction load, update buffer, bypass and return to reset
`timescale 1ns/10ps
`default_nettype none
`include "jtb_defs.vh"
module tb;
	logic       core_clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       upd_ready = 1'b0;
	logic       clk_en = 1'b1;
	wire        tck, tms, tdi, tdo_o, tdo_oe, bypass_sel, upd_valid, upd_stall;
	wire  [7:0] instr_q, upd_data;
	wire  [3:0] tap_state;
	logic       q, oe;
	logic [7:0] d;
	int         failures = 0;
	int         compares = 0;
	int         cyc = 0;
	always #20 core_clk = ~core_clk;
	jtb_tap u_jtb_tap (.core_clk, .arst_n, .clk_en, .tck, .tms, .tdi, .tdo_o, .tdo_oe,
		.instr_q, .bypass_sel, .upd_data, .upd_valid, .upd_ready, .upd_stall, .tap_state);
	jtb_ctl_model u_jtb_ctl_model (.clk(core_clk), .tdo_o, .tdo_oe, .tck, .tms, .tdi);
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Step n states, mode bits lowest first
	task automatic walk(input logic [7:0] m, input int n);
		for (int i = 0; i < n; i++) u_jtb_ctl_model.step(m[i], 1'b0, q, oe);
	endtask
	// Shift n bits lowest first, mode high on the last; output gathered in d
	task automatic scan(input logic [7:0] v, input int n);
		d = 8'h00;
		for (int i = 0; i < n; i++) begin
			u_jtb_ctl_model.step(i == n - 1, v[i], q, oe);
			d[i] = q;
			check({7'h00, oe}, 8'h01);
		end
	endtask
	// From idle: load an instruction and return to idle
	task automatic ld_ir(input logic [7:0] v);
		walk(8'h03, 4);
		scan(v, 8);
		check(d, `JTB_IR_CAPTURE);
		walk(8'h01, 1);
		check({7'h00, oe}, 8'h00);
		walk(8'h00, 1);
		check(instr_q, v);
		check({7'h00, bypass_sel}, {7'h00, v == 8'hff});
	endtask
	task automatic t_ir_load;
		walk(8'h00, 1);
		ld_ir(8'h00);
		$display("ir load done");
	endtask
	// Nine updates against a stalled consumer: eight kept, the ninth lost
	task automatic t_fifo;
		for (int i = 0; i < 9; i++) begin
			walk(8'h01, 3);
			scan(i[7:0], 8);
			walk(8'h01, 2);
		end
		check({6'h00, upd_valid, upd_stall}, 8'h03);
		// Enable low freezes the queue even with the consumer ready
		clk_en = 1'b0;
		upd_ready = 1'b1;
		repeat (4) @(negedge core_clk);
		check({6'h00, upd_valid, upd_stall}, 8'h03);
		check(upd_data, 8'h00);
		upd_ready = 1'b0;
		clk_en = 1'b1;
		@(negedge core_clk);
		for (int i = 0; i < 8; i++) begin
			check(upd_data, i[7:0]);
			upd_ready = 1'b1;
			@(negedge core_clk) upd_ready = 1'b0;
			@(negedge core_clk);
		end
		check({6'h00, upd_valid, upd_stall}, 8'h00);
		$display("fifo done");
	endtask
	// Bypass delays data one stage; its update is not buffered
	task automatic t_bypass;
		ld_ir(8'hff);
		walk(8'h01, 3);
		scan(8'h05, 3);
		check(d, 8'h02);
		// Park in pause-DR on the way out, then leave through exit2 and update
		walk(8'h7c, 7);
		check({7'h00, oe}, 8'h00);
		check({4'h0, tap_state}, {4'h0, `JTB_ST_RESET});
		check({7'h00, upd_valid}, 8'h00);
		$display("bypass done");
	endtask
	// Main sequence
	initial begin
		repeat (8) @(negedge core_clk);
		arst_n = 1'b1;
		@(negedge core_clk);
		t_ir_load;
		t_fifo;
		t_bypass;
		end_sim;
	end
	// Hang limit, well above the expected run
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			end_sim;
		end
	end
endmodule // tb
`default_nettype wire
